//--- uhp_host_port.sv
// host bus port, modem pins and interrupt pin of one uart channel
//
// Contract
// R1 - eight-bit data bus, driven only while the host reads a register
// R2 - bus bit 0 is the character lsb, first shifted on the line
// R3 - modem control bit 0 set drives dtr low; clear or reset raises it
// R4 - in rs-485 mode dtr serves as external driver direction control
// R5 - irq asserts only with mcr bit 3, enabled source and pending condition; the code also asserts it with override high and mcr bit 3 clear
// R6 - sources: line error, rx data, tx holding empty, modem status change
// R7 - reset places the interrupt output in high impedance
// R8 - override input high keeps irq driven regardless of mcr bit 3
// R9 - override low: mcr bit 3 one enables irq driver, zero floats it
// R10 - read strobe low drives the addressed register onto the bus
// R11 - write strobe low loads bus data into the addressed register
// R12 - active-high reset returns all registers and outputs to reset state
// R13 - during reset serial transmit output and receive input are disabled
// R14 - ring indicator low-to-high edge raises modem status interrupt
// R15 - modem control bit 1 set drives rts low; high after reset
// R16 - rts steers flow only when automatic rts is enabled
// R17 - loopback ignores the external rx pin and feeds tx back
// R18 - rx ready low on trigger or timeout, high when fifos empty
// R19 - host selects the channel with its chip select low during strobes
// R20 - host never asserts read and write strobes together
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "uhp_defs.svh"
module uhp_host_port (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // host bus pins
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   input wire logic i_channel_select_n,
   input wire logic [2:0] i_reg_addr_bit,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe_n,
   // modem and interrupt pins
   input wire logic i_ring_n,
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_cd_n,
   input wire logic i_irq_drive_override,
   output logic o_dtr_n,
   output logic o_rts_n,
   output logic o_channel_irq_out,
   output logic o_channel_irq_oe_n,
   // serial path
   input wire logic i_rx,
   input wire logic i_tx_core,
   input wire logic i_rx_fifo_flow_stop,
   output logic o_tx,
   output logic o_rx_core,
   output logic o_rts_flow_active,
   // core status and rx ready
   input wire logic i_line_error,
   input wire logic i_rx_data_avail,
   input wire logic i_tx_hold_empty,
   input wire logic [7:0] i_rx_holding,
   input wire logic [7:0] i_lsr,
   input wire logic i_rx_trigger,
   input wire logic i_rx_timeout,
   input wire logic i_rx_fifo_empty,
   output logic o_rx_dma_request_n,
   output logic [7:0] o_tx_holding,
   output logic o_tx_holding_load
);
   // ********************************************************
   // pin synchronisers
   // ********************************************************
   logic [7:0] pin_async;
   logic [7:0] pin_sync;
   logic [2:0] addr_s;
   logic rd_s_n, wr_s_n, cs_s_n, ring_s_n, cts_s_n, dsr_s_n, cd_s_n;
   logic rx_s, override_s;
   logic [7:0] data_s;
   assign pin_async = {i_read_strobe_n, i_write_strobe_n, i_channel_select_n, i_ring_n,
                       i_cts_n, i_dsr_n, i_cd_n, i_rx};
   uhp_sync #(.WIDTH(8), .INIT(8'hff)) u_sync_ctl (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(pin_async),
      .o_sync(pin_sync)
   );
   uhp_sync #(.WIDTH(12), .INIT(12'h000)) u_sync_data (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async({i_irq_drive_override, i_reg_addr_bit, i_data}),
      .o_sync({override_s, addr_s, data_s})
   );
   assign {rd_s_n, wr_s_n, cs_s_n, ring_s_n, cts_s_n, dsr_s_n, cd_s_n, rx_s} = pin_sync;

   // ********************************************************
   // strobe decode
   // ********************************************************
   uhp_pkg::uhp_bus_s bus;
   uhp_pkg::uhp_access_e access;
   logic wr_seen_reg;
   logic wr_go;
   assign bus = '{rd_n: rd_s_n, wr_n: wr_s_n, cs_n: cs_s_n, addr: addr_s};
   always_comb
   begin
      if (bus.cs_n)
         access = uhp_pkg::UHP_IDLE;
      else if (!bus.rd_n && bus.wr_n) // R20
         access = uhp_pkg::UHP_READ;
      else if (!bus.wr_n && bus.rd_n)
         access = uhp_pkg::UHP_WRITE;
      else
         access = uhp_pkg::UHP_IDLE;
   end
   // one load per strobe: data taken on the first cycle it is seen low
   assign wr_go = (access == uhp_pkg::UHP_WRITE) && !wr_seen_reg; // R11 R19
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         wr_seen_reg <= 1'b0;
      else
         wr_seen_reg <= (access == uhp_pkg::UHP_WRITE);
   end

   // ********************************************************
   // registers
   // ********************************************************
   logic [7:0] mcr_reg, ier_reg, efr_reg, lcr_reg, scratch_reg;
   always_ff @(posedge i_clock)
   begin
      if (i_rst) // R12
      begin
         mcr_reg <= `UHP_REG_RESET;
         ier_reg <= `UHP_REG_RESET;
         efr_reg <= `UHP_REG_RESET;
         lcr_reg <= `UHP_REG_RESET;
         scratch_reg <= `UHP_REG_RESET;
      end
      else if (wr_go)
      begin
         case (bus.addr)
            `UHP_ADDR_IER: ier_reg <= data_s;
            `UHP_ADDR_LCR: lcr_reg <= data_s;
            `UHP_ADDR_MCR: mcr_reg <= data_s;
            `UHP_ADDR_EFR: efr_reg <= data_s;
            `UHP_ADDR_IIR: scratch_reg <= data_s;
            default: scratch_reg <= scratch_reg;
         endcase
      end
   end
   // address zero write hands the character to the transmitter, bit 0 first on the line
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_tx_holding <= `UHP_REG_RESET;
         o_tx_holding_load <= 1'b0;
      end
      else
      begin
         o_tx_holding_load <= wr_go && (bus.addr == 3'h0); // R2
         if (wr_go && (bus.addr == 3'h0))
            o_tx_holding <= data_s;
      end
   end

   // ********************************************************
   // modem status and interrupt sources
   // ********************************************************
   logic [3:0] modem_prev_reg;
   logic [3:0] modem_delta_reg;
   logic [3:0] modem_now;
   logic [3:0] modem_change;
   logic msr_read;
   assign modem_now = {~cd_s_n, ~ring_s_n, ~dsr_s_n, ~cts_s_n};
   assign msr_read = (access == uhp_pkg::UHP_READ) && (bus.addr == `UHP_ADDR_MSR);
   always_comb
   begin
      modem_change = modem_now ^ modem_prev_reg;
      // ring counts only its trailing edge: pin goes back high
      modem_change[2] = modem_prev_reg[2] && !modem_now[2]; // R14
   end
   // a change in the same cycle as the status read stays pending
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         modem_prev_reg <= 4'h0;
         modem_delta_reg <= 4'h0;
      end
      else
      begin
         modem_prev_reg <= modem_now;
         modem_delta_reg <= (msr_read ? 4'h0 : modem_delta_reg) | modem_change;
      end
   end
   logic src_line, src_rx, src_tx, src_modem, irq_pending;
   assign src_line = i_line_error && ier_reg[`UHP_IER_LINE]; // R6
   assign src_rx = i_rx_data_avail && ier_reg[`UHP_IER_RX_DATA]; // R6
   assign src_tx = i_tx_hold_empty && ier_reg[`UHP_IER_TX_EMPTY]; // R6
   assign src_modem = (|modem_delta_reg) && ier_reg[`UHP_IER_MODEM]; // R6 R14
   assign irq_pending = src_line | src_rx | src_tx | src_modem;

   // ********************************************************
   // read path
   // ********************************************************
   logic [7:0] iir_value;
   logic [7:0] read_value;
   always_comb
   begin
      if (src_line)
         iir_value = `UHP_IIR_LINE;
      else if (src_rx)
         iir_value = `UHP_IIR_RX;
      else if (src_tx)
         iir_value = `UHP_IIR_TX;
      else if (src_modem)
         iir_value = `UHP_IIR_MODEM;
      else
         iir_value = `UHP_IIR_NONE;
   end
   always_comb
   begin
      case (bus.addr)
         3'h0: read_value = i_rx_holding;
         `UHP_ADDR_IER: read_value = ier_reg;
         `UHP_ADDR_IIR: read_value = iir_value;
         `UHP_ADDR_LCR: read_value = lcr_reg;
         `UHP_ADDR_MCR: read_value = mcr_reg;
         `UHP_ADDR_LSR: read_value = i_lsr;
         `UHP_ADDR_MSR: read_value = {modem_now, modem_delta_reg};
         `UHP_ADDR_EFR: read_value = efr_reg;
         default: read_value = `UHP_REG_RESET;
      endcase
   end
   // bus floats except during a selected read strobe
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_data <= `UHP_REG_RESET;
         o_data_oe_n <= 1'b1;
      end
      else
      begin
         o_data <= read_value; // R10
         o_data_oe_n <= !(access == uhp_pkg::UHP_READ); // R1 R10
      end
   end

   // ********************************************************
   // modem outputs and interrupt pin
   // ********************************************************
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_dtr_n <= 1'b1;
         o_rts_n <= 1'b1;
      end
      else
      begin
         // rs-485 direction follows the same bit, so no separate pin logic
         o_dtr_n <= !mcr_reg[`UHP_MCR_DTR]; // R3 R4
         o_rts_n <= !mcr_reg[`UHP_MCR_RTS]; // R15
      end
   end
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         o_rts_flow_active <= 1'b0;
      else
         o_rts_flow_active <= efr_reg[`UHP_EFR_AUTO_RTS] && !i_rx_fifo_flow_stop; // R16
   end
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_channel_irq_out <= 1'b0;
         o_channel_irq_oe_n <= 1'b1; // R7
      end
      else
      begin
         o_channel_irq_out <= irq_pending && (mcr_reg[`UHP_MCR_IRQ_EN] || override_s); // R5
         o_channel_irq_oe_n <= !(override_s || mcr_reg[`UHP_MCR_IRQ_EN]); // R8 R9
      end
   end

   // ********************************************************
   // serial steering and rx ready
   // ********************************************************
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_tx <= 1'b1; // R13
         o_rx_core <= 1'b1; // R13
      end
      else if (mcr_reg[`UHP_MCR_LOOP])
      begin
         o_tx <= 1'b1;
         o_rx_core <= i_tx_core; // R17
      end
      else
      begin
         o_tx <= i_tx_core;
         o_rx_core <= rx_s;
      end
   end
   // low on trigger or timeout, held until the fifo drains
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
         o_rx_dma_request_n <= 1'b1;
      else if (i_rx_trigger || i_rx_timeout)
         o_rx_dma_request_n <= 1'b0; // R18
      else if (i_rx_fifo_empty)
         o_rx_dma_request_n <= 1'b1; // R18
   end
endmodule : uhp_host_port
`default_nettype wire

//--- uhp_defs.svh
// constants for the uart host port and modem pin block
`ifndef UHP_DEFS_SVH
`define UHP_DEFS_SVH
`define UHP_ADDR_IER 3'h1
`define UHP_ADDR_IIR 3'h2
`define UHP_ADDR_LCR 3'h3
`define UHP_ADDR_MCR 3'h4
`define UHP_ADDR_LSR 3'h5
`define UHP_ADDR_MSR 3'h6
`define UHP_ADDR_EFR 3'h7
`define UHP_MCR_DTR 0
`define UHP_MCR_RTS 1
`define UHP_MCR_IRQ_EN 3
`define UHP_MCR_LOOP 4
`define UHP_MCR_RS485 5
`define UHP_EFR_AUTO_RTS 6
`define UHP_IER_RX_DATA 0
`define UHP_IER_TX_EMPTY 1
`define UHP_IER_LINE 2
`define UHP_IER_MODEM 3
`define UHP_REG_RESET 8'h00
`define UHP_IIR_NONE 8'h01
`define UHP_IIR_LINE 8'h06
`define UHP_IIR_RX 8'h04
`define UHP_IIR_TX 8'h02
`define UHP_IIR_MODEM 8'h00
`endif

//--- uhp_pkg.sv
// types shared by the uart host port block
package uhp_pkg;
   typedef struct packed {
      logic rd_n;
      logic wr_n;
      logic cs_n;
      logic [2:0] addr;
   } uhp_bus_s;
   typedef enum logic [1:0] {
      UHP_IDLE,
      UHP_READ,
      UHP_WRITE
   } uhp_access_e;
endpackage : uhp_pkg

//--- uhp_sync.sv
// two-stage synchroniser with a reset value
`timescale 1ns/100ps
`default_nettype none
module uhp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1_reg;
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         stage1_reg <= INIT;
         o_sync <= INIT;
      end
      else
      begin
         stage1_reg <= i_async;
         o_sync <= stage1_reg;
      end
   end
endmodule : uhp_sync
`default_nettype wire

//--- uhp_host_port_assertions.sv
// pin level checks for the uart host port
`timescale 1ns/100ps
`default_nettype none
module uhp_host_port_assertions (
   // clock, reset and watched pins
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   input wire logic i_channel_select_n,
   input wire logic i_irq_drive_override,
   input wire logic i_rx_trigger,
   input wire logic i_rx_timeout,
   input wire logic i_rx_fifo_empty,
   input wire logic i_rx_fifo_flow_stop,
   input wire logic o_data_oe_n,
   input wire logic o_dtr_n,
   input wire logic o_channel_irq_oe_n,
   input wire logic o_tx,
   input wire logic o_rx_core,
   input wire logic o_rts_flow_active,
   input wire logic o_rx_dma_request_n
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ****
   // properties
   // ****
   // four edges: two sync flops, the output register and the sampling edge
   property p_read_drive;
      (!i_read_strobe_n && !i_channel_select_n && i_write_strobe_n) [*4] |-> !o_data_oe_n;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("bus not driven");
   property p_bus_float;
      i_read_strobe_n [*4] |-> o_data_oe_n;
   endproperty
   a_bus_float: assert property (p_bus_float) else $error("bus driven idle");
   property p_dtr_rst;
      $fell(i_rst) |-> o_dtr_n;
   endproperty
   a_dtr_rst: assert property (p_dtr_rst) else $error("dtr low after reset");
   property p_irq_rst;
      $fell(i_rst) |-> o_channel_irq_oe_n;
   endproperty
   a_irq_rst: assert property (p_irq_rst) else $error("irq driven after reset");
   property p_tx_rst;
      $fell(i_rst) |-> o_tx && o_rx_core;
   endproperty
   a_tx_rst: assert property (p_tx_rst) else $error("serial path live in reset");
   property p_override;
      i_irq_drive_override [*4] |-> !o_channel_irq_oe_n;
   endproperty
   a_override: assert property (p_override) else $error("override ignored");
   property p_dma_set;
      i_rx_trigger || i_rx_timeout |=> !o_rx_dma_request_n;
   endproperty
   a_dma_set: assert property (p_dma_set) else $error("rx ready not low");
   property p_dma_clr;
      i_rx_fifo_empty && !i_rx_trigger && !i_rx_timeout |=> o_rx_dma_request_n;
   endproperty
   a_dma_clr: assert property (p_dma_clr) else $error("rx ready not high");
   property p_flow;
      i_rx_fifo_flow_stop |=> !o_rts_flow_active;
   endproperty
   a_flow: assert property (p_flow) else $error("flow active while stopped");
   c_read: cover property (!o_data_oe_n);
   c_irq: cover property (!o_channel_irq_oe_n);
   c_dma: cover property ($fell(o_rx_dma_request_n));
endmodule : uhp_host_port_assertions
`default_nettype wire

//--- uhp_host_model.sv
// host cpu model driving the register bus pins
`timescale 1ns/100ps
`default_nettype none
module uhp_host_model (
   // clock and bus
   input wire logic i_clock,
   input wire logic [7:0] i_data,
   output var uhp_pkg::uhp_bus_s o_bus,
   output logic [7:0] o_wdata,
   output logic o_wdata_en
);
   initial
   begin
      o_bus = '{1'b1, 1'b1, 1'b1, 3'h0};
      o_wdata = 8'h00;
      o_wdata_en = 1'b0;
   end
   // strobe low five clocks, high four: the pins are synced and the bus release lags
   task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] v,
      output logic [7:0] q);
      @(posedge i_clock);
      o_bus <= '{wr, !wr, 1'b0, a};
      o_wdata <= v;
      o_wdata_en <= wr;
      repeat (5) @(posedge i_clock);
      q = i_data;
      o_bus <= '{1'b1, 1'b1, 1'b1, a};
      o_wdata_en <= 1'b0;
      repeat (4) @(posedge i_clock);
   endtask : access
endmodule : uhp_host_model
`default_nettype wire

//--- uhp_host_port_tb.sv
// self-checking bench for the uart host port block
`timescale 1ns/100ps
`default_nettype none
`include "uhp_defs.svh"
module uhp_host_port_tb;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_ring_n = 1'b1, i_irq_drive_override = 1'b0, i_rx = 1'b1, i_tx_core = 1'b1;
   logic i_rx_fifo_flow_stop = 1'b0, i_line_error = 1'b0, i_rx_data_avail = 1'b0;
   logic i_tx_hold_empty = 1'b0, i_rx_trigger = 1'b0, i_rx_timeout = 1'b0, i_rx_fifo_empty = 1'b1;
   logic [7:0] i_rx_holding = 8'ha5, o_data, o_tx_holding, rd, wdata;
   logic o_data_oe_n, o_dtr_n, o_rts_n, o_channel_irq_out, o_channel_irq_oe_n, o_tx, o_rx_core;
   logic o_rts_flow_active, o_rx_dma_request_n, wen, o_tx_holding_load, load_seen = 1'b0;
   logic [7:0] codes [3] = '{`UHP_IIR_RX, `UHP_IIR_TX, `UHP_IIR_LINE};
   uhp_pkg::uhp_bus_s bus;
   wire logic [7:0] data_w;
   int fail_count = 0, check_count = 0;
   always #50 i_clock = ~i_clock;
   // a released bus shows the inverse of the last byte, never a held value
   assign data_w = !o_data_oe_n ? o_data : (wen ? wdata : ~wdata);
   uhp_host_model hst_u (.i_clock, .i_data(data_w), .o_bus(bus), .o_wdata(wdata), .o_wdata_en(wen));
   uhp_host_port dut_u (
      .i_clock, .i_rst, .i_read_strobe_n(bus.rd_n), .i_write_strobe_n(bus.wr_n),
      .i_channel_select_n(bus.cs_n), .i_reg_addr_bit(bus.addr), .i_data(data_w), .o_data,
      .o_data_oe_n, .i_ring_n, .i_cts_n(1'b1), .i_dsr_n(1'b1), .i_cd_n(1'b1),
      .i_irq_drive_override, .o_dtr_n, .o_rts_n, .o_channel_irq_out, .o_channel_irq_oe_n,
      .i_rx, .i_tx_core, .i_rx_fifo_flow_stop, .o_tx, .o_rx_core, .o_rts_flow_active,
      .i_line_error, .i_rx_data_avail, .i_tx_hold_empty, .i_rx_holding, .i_lsr(8'h60),
      .i_rx_trigger, .i_rx_timeout, .i_rx_fifo_empty, .o_rx_dma_request_n, .o_tx_holding,
      .o_tx_holding_load);
   // the load strobe is one cycle long, so latch it for the check after the write
   always @(posedge i_clock)
   begin
      if (o_tx_holding_load)
         load_seen <= 1'b1;
   end
   // ****
   // tasks
   // ****
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      hst_u.access(1'b1, a, v, rd);
   endtask : wr
   task automatic rdc(input string n, input logic [2:0] a, input logic [7:0] e);
      hst_u.access(1'b0, a, 8'h00, rd);
      chk(n, e, rd);
   endtask : rdc
   // two sync flops, a status flop, the output register and a spare edge
   task automatic settle;
      repeat (5) @(posedge i_clock);
   endtask : settle
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // ****
   // tests
   // ****
   initial
   begin
      repeat (12) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      chk("reset pins", 8'h1f, {2'h0, o_channel_irq_out, o_dtr_n, o_rts_n, o_channel_irq_oe_n,
         o_tx, o_data_oe_n});
      rdc("mcr reset", `UHP_ADDR_MCR, 8'h00);
      wr(`UHP_ADDR_MCR, 8'h03);
      chk("dtr rts", 8'h00, {6'h0, o_dtr_n, o_rts_n});
      rdc("mcr back", `UHP_ADDR_MCR, 8'h03);
      wr(`UHP_ADDR_MCR, 8'h21);
      chk("rs485 dtr", 8'h01, {6'h0, o_dtr_n, o_rts_n});
      wr(`UHP_ADDR_MCR, 8'h00);
      chk("dtr off", 8'h01, {7'h0, o_dtr_n});
      wr(3'h0, 8'h01);
      chk("tx byte", 8'h01, o_tx_holding);
      chk("tx load", 8'h01, {7'h0, load_seen});
      rdc("rx byte", 3'h0, 8'ha5);
      $display("test bus done");
      wr(`UHP_ADDR_MCR, 8'h08);
      for (int k = 0; k < 3; k++)
      begin
         wr(`UHP_ADDR_IER, 8'h01 << k);
         {i_rx_data_avail, i_tx_hold_empty, i_line_error} <= 3'b100 >> k;
         settle();
         chk("irq on", 8'h02, {6'h0, o_channel_irq_out, o_channel_irq_oe_n});
         rdc("irq id", `UHP_ADDR_IIR, codes[k]);
         wr(`UHP_ADDR_IER, 8'h00);
         chk("irq masked", 8'h00, {7'h0, o_channel_irq_out});
      end
      {i_rx_data_avail, i_tx_hold_empty, i_line_error} <= 3'b000;
      wr(`UHP_ADDR_IER, 8'h08);
      i_ring_n <= 1'b0;
      settle();
      chk("ring fall", 8'h00, {7'h0, o_channel_irq_out});
      i_ring_n <= 1'b1;
      settle();
      chk("ring rise", 8'h01, {7'h0, o_channel_irq_out});
      rdc("modem id", `UHP_ADDR_IIR, `UHP_IIR_MODEM);
      wr(`UHP_ADDR_MCR, 8'h00);
      chk("irq float", 8'h01, {7'h0, o_channel_irq_oe_n});
      i_irq_drive_override <= 1'b1;
      settle();
      chk("irq forced", 8'h00, {7'h0, o_channel_irq_oe_n});
      i_irq_drive_override <= 1'b0;
      $display("test irq done");
      wr(`UHP_ADDR_MCR, 8'h10);
      i_rx <= 1'b0;
      i_tx_core <= 1'b0;
      settle();
      chk("loop low", 8'h02, {6'h0, o_tx, o_rx_core});
      i_tx_core <= 1'b1;
      settle();
      chk("loop high", 8'h03, {6'h0, o_tx, o_rx_core});
      wr(`UHP_ADDR_MCR, 8'h00);
      chk("normal path", 8'h02, {6'h0, o_tx, o_rx_core});
      i_rx <= 1'b1;
      wr(`UHP_ADDR_EFR, 8'h40);
      chk("auto rts", 8'h01, {7'h0, o_rts_flow_active});
      wr(`UHP_ADDR_EFR, 8'h00);
      chk("manual rts", 8'h00, {7'h0, o_rts_flow_active});
      $display("test serial done");
      i_rx_trigger <= 1'b1;
      i_rx_fifo_empty <= 1'b0;
      settle();
      i_rx_trigger <= 1'b0;
      settle();
      chk("rx ready held", 8'h00, {7'h0, o_rx_dma_request_n});
      i_rx_fifo_empty <= 1'b1;
      settle();
      chk("rx ready empty", 8'h01, {7'h0, o_rx_dma_request_n});
      $display("test dma done");
      end_of_test();
   end
   initial
   begin
      repeat (5000) @(posedge i_clock);
      fail_count++;
      end_of_test();
   end
endmodule : uhp_host_port_tb
bind uhp_host_port uhp_host_port_assertions chk_u (.i_clock, .i_rst, .i_read_strobe_n,
   .i_write_strobe_n, .i_channel_select_n, .i_irq_drive_override, .i_rx_trigger, .i_rx_timeout,
   .i_rx_fifo_empty, .i_rx_fifo_flow_stop, .o_data_oe_n, .o_dtr_n, .o_channel_irq_oe_n, .o_tx,
   .o_rx_core, .o_rts_flow_active, .o_rx_dma_request_n);
`default_nettype wire
